/* File: verification/cct_compare_unit_asserts.sv */
/*
   Checker for the counter compare table unit, bound to its top module.
   Assumes one clock and a synchronous active-low reset.
*/
`timescale 1ns/100ps
module cct_compare_unit_asserts
#(
   parameter NCNT = 6
)
(
   input wire               clk,
   input wire               rst_b,
   input wire               tbl_wr_en,
   input wire [4:0]         tbl_wr_addr,
   input wire [15:0]        tbl_wr_data,
   input wire               trc_valid,
   input wire [15:0]        trc_port,
   input wire [15:0]        trc_code,
   input wire               trc_ready,
   input wire               trc_done,
   input wire               mcc_start,
   input wire               mcc_stop,
   input wire [15:0]        mcc_port,
   input wire [NCNT-1:0]    hsc_enabled,
   input wire [NCNT-1:0]    incr_pulse_mode,
   input wire [NCNT-1:0]    ring_mode,
   input wire [NCNT-1:0]    count_down,
   input wire [NCNT*32-1:0] present_count_value,
   input wire [NCNT*32-1:0] ring_max,
   input wire               program_mode,
   input wire               instruction_error_flag,
   input wire               cmp_running,
   input wire               cmp_method,
   input wire               evt_valid,
   input wire [15:0]        evt_task,
   input wire [5:0]         range_in_progress
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_b);
   wire take = trc_valid && trc_ready;
   done_latency_a: assert property (take |-> ##[33:34] trc_done)
      else $error("table command did not complete in time");
   busy_after_a: assert property (take |=> !trc_ready)
      else $error("loader idle right after a command");
   done_pulse_a: assert property (trc_done |=> !trc_done)
      else $error("completion pulse longer than one cycle");
   bad_code_a: assert property (take && (trc_port > 16'h0005 ||
      trc_code > 16'h0003) |-> ##[33:34] (trc_done && instruction_error_flag))
      else $error("bad port or code not flagged");
   err_source_a: assert property ($changed(instruction_error_flag)
      |-> trc_done)
      else $error("error flag moved without a command");
   err_keep_a: assert property (trc_done && instruction_error_flag
      |-> $stable(cmp_running) && $stable(cmp_method))
      else $error("rejected table changed the comparison state");
   run_cause_a: assert property ($rose(cmp_running)
      |-> trc_done || $past(mcc_start))
      else $error("comparison started without a cause");
   prog_stop_a: assert property (program_mode |=> !cmp_running)
      else $error("comparison running in program mode");
   tgt_task_a: assert property (evt_valid && !cmp_method
      |-> !evt_task[15])
      else $error("direction bit left in target task");
   quiet_task_a: assert property (evt_valid && cmp_method
      |-> evt_task != 16'hAAAA && evt_task != 16'hFFFF)
      else $error("event raised for a silent or disabled range");
endmodule

/* File: verification/cct_compare_unit_tb_top.sv */
/*
   Self-checking bench for the counter compare table unit.
   Assumes the counter model drives counter 0; others stay at zero.
*/
`timescale 1ns/100ps
module cct_compare_unit_tb_top;
   reg clk = 0, rst_b = 0, tbl_wr_en = 0, trc_valid = 0;
   reg mcc_start = 0, mcc_stop = 0, program_mode = 0, step = 0, down_in = 0;
   reg [4:0] tbl_wr_addr = 0;
   reg [15:0] tbl_wr_data = 0, trc_port = 0, trc_code = 0, mcc_port = 0;
   reg [5:0] hsc_enabled = 6'h3D, incr_pulse_mode = 0, ring_mode = 0;
   reg [191:0] ring_max = {6{32'h0000_0064}};
   wire [31:0] pv;
   wire down, trc_ready, trc_done, instruction_error_flag;
   wire cmp_running, cmp_method, evt_valid;
   wire [15:0] evt_task;
   wire [5:0] range_in_progress;
   integer n_errors = 0, n_tests = 0, i;
   always #2 clk = ~clk;
   cct_counter_model u_cnt (.clk(clk), .rst_b(rst_b), .step(step),
      .down_in(down_in), .pv(pv), .down(down));
   cct_compare_unit #(.NCNT(6)) u_dut (.clk(clk), .rst_b(rst_b),
      .tbl_wr_en(tbl_wr_en), .tbl_wr_addr(tbl_wr_addr),
      .tbl_wr_data(tbl_wr_data), .trc_valid(trc_valid),
      .trc_port(trc_port), .trc_code(trc_code), .trc_ready(trc_ready),
      .trc_done(trc_done), .mcc_start(mcc_start), .mcc_stop(mcc_stop),
      .mcc_port(mcc_port), .hsc_enabled(hsc_enabled),
      .incr_pulse_mode(incr_pulse_mode), .ring_mode(ring_mode),
      .count_down({5'h0, down}), .present_count_value({160'h0, pv}),
      .ring_max(ring_max), .program_mode(program_mode),
      .instruction_error_flag(instruction_error_flag),
      .cmp_running(cmp_running), .cmp_method(cmp_method),
      .evt_valid(evt_valid), .evt_task(evt_task),
      .range_in_progress(range_in_progress));
   // ------------------------------------------------------------------
   // Tasks
   // ------------------------------------------------------------------
   task tick;
   begin
      @(posedge clk);
      #1;
   end
   endtask
   task chk_b(input string nm, input e, input g);
   begin
      n_tests = n_tests + 1;
      if (g !== e)
      begin
         n_errors = n_errors + 1;
         $display("ERROR %0s expected %b seen %b", nm, e, g);
      end
   end
   endtask
   task chk_w(input string nm, input [15:0] e, input [15:0] g);
   begin
      n_tests = n_tests + 1;
      if (g !== e)
      begin
         n_errors = n_errors + 1;
         $display("ERROR %0s expected %h seen %h", nm, e, g);
      end
   end
   endtask
   task close_out;
   begin
      $display("comparisons %0d mismatches %0d", n_tests, n_errors);
      if (n_errors == 0 && n_tests > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   end
   endtask
   task wr(input [4:0] a, input [15:0] d);
   begin
      tbl_wr_en = 1; tbl_wr_addr = a; tbl_wr_data = d; tick;
      tbl_wr_en = 0; tick;
   end
   endtask
   task put32(input [4:0] k, input [31:0] v);
   begin
      wr(k, v[15:0]); wr(k + 5'h1, v[31:16]);
   end
   endtask
   task put_r(input [4:0] r, input [31:0] lo, hi, input [15:0] tk);
   begin
      put32(r * 5, lo); put32(r * 5 + 2, hi); wr(r * 5 + 4, tk);
   end
   endtask
   // One request pulse per command, as a single-scan edge would give.
   task cmd(input [15:0] p, c, input e);
   integer n;
   begin
      trc_port = p; trc_code = c; trc_valid = 1; tick; trc_valid = 0;
      n = 0;
      while (trc_done !== 1'b1 && n < 40)
      begin
         tick; n = n + 1;
      end
      chk_b("done", 1'b1, trc_done);
      chk_b("error_flag", e, instruction_error_flag);
   end
   endtask
   task mc(input s, p, e);
   begin
      mcc_start = s; mcc_stop = p; tick; mcc_start = 0; mcc_stop = 0; tick;
      chk_b("running", e, cmp_running);
   end
   endtask
   task step_w(input dn, ev, input [15:0] tk);
   reg s;
   reg [15:0] t;
   integer n;
   begin
      step = 1; down_in = dn; tick; step = 0; s = 0; t = 0;
      for (n = 0; n < 6; n = n + 1)
      begin
         if (evt_valid === 1'b1 && !s)
         begin
            s = 1; t = evt_task;
         end
         tick;
      end
      chk_b("event", ev, s);
      if (ev)
         chk_w("task", tk, t);
   end
   endtask
   task err_c(input [15:0] p, c, n, input [31:0] v, input [15:0] tk);
   begin
      wr(0, n); put32(1, v); wr(3, tk); put32(4, v); wr(6, tk);
      cmd(p, c, 1);
      chk_b("running", 1, cmp_running);
   end
   endtask
   // ------------------------------------------------------------------
   // Tests
   // ------------------------------------------------------------------
   initial
   begin
      #100000;
      n_errors = n_errors + 1;
      close_out;
   end
   initial
   begin
      repeat (3) @(posedge clk);
      #1 rst_b = 1;
      wr(0, 2); put32(1, 3); wr(3, 16'h0001); put32(4, 2); wr(6, 16'h8002);
      cmd(0, 0, 0);
      chk_b("method", 0, cmp_method);
      step_w(0, 0, 0);
      step_w(0, 0, 0);
      step_w(0, 1, 16'h0001);
      step_w(1, 1, 16'h0002);
      mc(0, 1, 0);
      step_w(0, 0, 0);
      mc(1, 0, 1);
      $display("target test done");
      err_c(6, 0, 1, 9, 1);
      err_c(0, 4, 1, 9, 1);
      err_c(1, 0, 1, 9, 1);
      err_c(0, 0, 0, 9, 1);
      err_c(0, 0, 7, 9, 1);
      incr_pulse_mode = 6'h01;
      err_c(0, 0, 2, 9, 1);
      err_c(0, 0, 1, 9, 16'h8001);
      incr_pulse_mode = 0; ring_mode = 6'h01;
      err_c(0, 0, 1, 200, 1);
      ring_mode = 0;
      err_c(0, 1, 1, 9, 1);
      $display("error test done");
      put_r(0, 4, 6, 3); put_r(1, 5, 9, 16'hAAAA); put_r(2, 5, 5, 7);
      for (i = 3; i < 6; i = i + 1)
         put_r(i, 0, 0, 16'hFFFF);
      cmd(0, 1, 1);
      mc(0, 1, 0);
      cmd(0, 1, 0);
      chk_b("method", 1, cmp_method);
      step_w(0, 1, 16'h0003);
      step_w(0, 1, 16'h0007);
      chk_w("in_range", 16'h0007, {10'h0, range_in_progress});
      step_w(0, 0, 0);
      for (i = 0; i < 6; i = i + 1)
         put_r(i, 0, 0, 16'hFFFF);
      cmd(0, 1, 1);
      put_r(0, 9, 4, 1);
      cmd(0, 1, 1);
      put_r(0, 4, 6, 3);
      cmd(0, 3, 0);
      chk_b("running", 0, cmp_running);
      mc(1, 0, 1);
      program_mode = 1; tick; program_mode = 0; tick;
      chk_b("running", 0, cmp_running);
      mc(1, 0, 0);
      wr(0, 1); put32(1, 9); wr(3, 1);
      cmd(0, 2, 0);
      chk_b("running", 0, cmp_running);
      mc(1, 0, 1);
      $display("range test done");
      close_out;
   end
endmodule
bind cct_compare_unit cct_compare_unit_asserts #(.NCNT(NCNT)) u_chk (
   .clk, .rst_b, .tbl_wr_en, .tbl_wr_addr, .tbl_wr_data, .trc_valid,
   .trc_port, .trc_code, .trc_ready, .trc_done, .mcc_start, .mcc_stop,
   .mcc_port, .hsc_enabled, .incr_pulse_mode, .ring_mode, .count_down,
   .present_count_value, .ring_max, .program_mode,
   .instruction_error_flag, .cmp_running, .cmp_method, .evt_valid,
   .evt_task, .range_in_progress);

/* File: verification/cct_counter_model.sv */
/*
   Model of counter 0: steps its value up or down on request.
   Assumes stimulus on clk and a synchronous active-low reset.
*/
`timescale 1ns/100ps
module cct_counter_model
(
   // Clock and reset
   clk,
   rst_b,
   // Step request
   step,
   down_in,
   // Counter state
   pv,
   down
);
   input  wire        clk;
   input  wire        rst_b;
   input  wire        step;
   input  wire        down_in;
   output reg  [31:0] pv;
   output reg         down;
   always @(posedge clk)
   begin
      if (!rst_b)
      begin
         pv   <= 32'h0;
         down <= 1'b0;
      end
      else if (step)
      begin
         down <= down_in;
         pv   <= down_in ? pv - 32'h1 : pv + 32'h1;
      end
   end
endmodule

/* File: verilog/cct_compare_unit.v */
/*
   Comparison unit for up to six high-speed counters: takes a staged
   target or range table, checks it, holds it and raises task events.
   Assumes counter values, modes and commands come from logic on clk.
*/
// What this block does
// - Port code 0..5 on enabled counter, else error
// - Code 0 stores target table, starts comparing
// - Code 1 stores range table, compares
// - Codes 2/3 store and halt comparison; start awaits command
// - Stop command halts comparison, whatever started it
// - Table stays until replaced or program mode
// - Each accepted code 0/1 command restarts comparison; pulse it
// - Target table: count, then value, task
// - Target count zero or above six errors
// - Value equal to target raises task event
// - Task bit 15 selects up or down
// - Every target compared every cycle
// - Duplicate value and direction errors, linear incremental mode
// - Down direction in incremental mode errors
// - Reversal on wrong-direction target: no event
// - Range table: six lower, upper, task
// - Upper below lower errors
// - All six ranges disabled errors
// - Range entry fires once, lowest first
// - Task AAAA updates flags, no event
// - Ring mode value above maximum errors
// - Other method while running errors, else clear
`timescale 1ns/100ps
`include "cct_consts.vh"
module cct_compare_unit
#(
   parameter NCNT = 6
)
(
   // Clock and reset
   input  wire              clk,
   input  wire              rst_b,
   // Table staging words
   input  wire              tbl_wr_en,
   input  wire [4:0]        tbl_wr_addr,
   input  wire [15:0]       tbl_wr_data,
   // Table register command
   input  wire              trc_valid,
   input  wire [15:0]       trc_port,
   input  wire [15:0]       trc_code,
   output wire              trc_ready,
   output reg               trc_done,
   // Mode control command
   input  wire              mcc_start,
   input  wire              mcc_stop,
   input  wire [15:0]       mcc_port,
   // Counter state and configuration
   input  wire [NCNT-1:0]   hsc_enabled,
   input  wire [NCNT-1:0]   incr_pulse_mode,
   input  wire [NCNT-1:0]   ring_mode,
   input  wire [NCNT-1:0]   count_down,
   input  wire [NCNT*32-1:0] present_count_value,
   input  wire [NCNT*32-1:0] ring_max,
   input  wire              program_mode,
   // Results
   output reg               instruction_error_flag,
   output reg               cmp_running,
   output reg               cmp_method,
   output reg               evt_valid,
   output reg  [15:0]       evt_task,
   output reg  [5:0]        range_in_progress
);

   // ----------------------------------------------------------------------
   // Loader states
   // ----------------------------------------------------------------------
   localparam ST_IDLE  = 3'b001;
   localparam ST_LOAD  = 3'b010;
   localparam ST_CHECK = 3'b100;

   reg  [2:0]  state_reg;
   reg  [4:0]  ld_addr_reg;
   reg  [4:0]  cap_idx_reg;
   reg         cap_en_reg;
   reg  [15:0] cmd_port_reg;
   reg  [15:0] cmd_code_reg;
   wire [15:0] ram_data;

   // Staged table, filled during the load walk.
   reg  [31:0] cand_lo [0:5];
   reg  [31:0] cand_hi [0:5];
   reg  [15:0] cand_task [0:5];
   reg  [15:0] cand_cnt_reg;

   // Table in force.
   reg  [31:0] act_lo [0:5];
   reg  [31:0] act_hi [0:5];
   reg  [15:0] act_task [0:5];
   reg  [2:0]  act_cnt_reg;
   reg  [2:0]  act_port_reg;
   reg         tbl_valid_reg;

   reg  [31:0] pv_prev_reg;
   reg  [5:0]  pend_reg;

   // Each process owns its loop index, so none is driven twice.
   integer     i;
   integer     ci;
   integer     cj;
   integer     ki;
   integer     gi;
   integer     xi;

   assign trc_ready = state_reg[0];

   cct_table_ram
   #(
      .AW    (5),
      .DW    (16),
      .DEPTH (32)
   )
   u_ram
   (
      .clk     (clk),
      .rst_b   (rst_b),
      .wr_en   (tbl_wr_en),
      .wr_addr (tbl_wr_addr),
      .wr_data (tbl_wr_data),
      .rd_addr (ld_addr_reg),
      .rd_data (ram_data)
   );

   // ----------------------------------------------------------------------
   // Table check
   // ----------------------------------------------------------------------
   wire       cmd_rng  = cmd_code_reg[0];
   wire       port_ok  = (cmd_port_reg <= `CCT_PORT_MAX);
   wire [2:0] psel     = port_ok ? cmd_port_reg[2:0] : 3'h0;
   wire       c_incr   = incr_pulse_mode[psel];
   wire       c_ring   = ring_mode[psel];
   wire [31:0] c_rmax  = ring_max[psel*32 +: 32];
   reg        err;
   reg        all_off;
   reg        used_i;

   always @*
   begin
      err     = 1'b0;
      all_off = 1'b1;
      used_i  = 1'b0;
      if (!port_ok || !hsc_enabled[psel])
         err = 1'b1;
      if (cmd_code_reg > `CCT_CODE_MAX)
         err = 1'b1;
      if (cmp_running && (cmp_method != cmd_rng))
         err = 1'b1;
      if (!cmd_rng)
      begin
         if ((cand_cnt_reg == 16'h0000) ||
             (cand_cnt_reg > `CCT_MAX_TARGETS))
            err = 1'b1;
         for (ci = 0; ci < 6; ci = ci + 1)
         begin
            used_i = (ci < cand_cnt_reg);
            if (used_i && c_incr && cand_task[ci][`CCT_DIR_BIT])
               err = 1'b1;
            if (used_i && c_ring && (cand_lo[ci] > c_rmax))
               err = 1'b1;
            for (cj = ci + 1; cj < 6; cj = cj + 1)
            begin
               if (used_i && (cj < cand_cnt_reg) && c_incr && !c_ring &&
                   (cand_lo[ci] == cand_lo[cj]) &&
                   (cand_task[ci][`CCT_DIR_BIT] ==
                    cand_task[cj][`CCT_DIR_BIT]))
                  err = 1'b1;
            end
         end
      end
      else
      begin
         for (ci = 0; ci < 6; ci = ci + 1)
         begin
            if (cand_task[ci] != `CCT_TASK_OFF)
            begin
               all_off = 1'b0;
               if (c_ring ? (cand_hi[ci] < cand_lo[ci]) :
                   ($signed(cand_hi[ci]) < $signed(cand_lo[ci])))
                  err = 1'b1;
               if (c_ring && ((cand_lo[ci] > c_rmax) ||
                              (cand_hi[ci] > c_rmax)))
                  err = 1'b1;
            end
         end
         if (all_off)
            err = 1'b1;
      end
   end

   // ----------------------------------------------------------------------
   // Comparison against the present count value
   // ----------------------------------------------------------------------
   wire [31:0] pv  = present_count_value[act_port_reg*32 +: 32];
   wire        dir = count_down[act_port_reg];
   wire        act_ring = ring_mode[act_port_reg];
   reg  [5:0]  hit;
   reg  [5:0]  inr;
   reg  [5:0]  grant;
   reg         lo_ok;
   reg         hi_ok;

   always @*
   begin
      hit   = 6'h00;
      inr   = 6'h00;
      lo_ok = 1'b0;
      hi_ok = 1'b0;
      for (ki = 0; ki < 6; ki = ki + 1)
      begin
         // A hit needs arrival on the value, so sitting on it or
         // reversing there in the wrong direction never fires.
         if (cmp_running && !cmp_method && (ki < act_cnt_reg) &&
             (pv != pv_prev_reg) && (pv == act_lo[ki]) &&
             (act_task[ki][`CCT_DIR_BIT] == dir))
            hit[ki] = 1'b1;
         lo_ok = act_ring ? (act_lo[ki] <= pv) :
                 ($signed(act_lo[ki]) <= $signed(pv));
         hi_ok = act_ring ? (pv <= act_hi[ki]) :
                 ($signed(pv) <= $signed(act_hi[ki]));
         if (cmp_running && cmp_method &&
             (act_task[ki] != `CCT_TASK_OFF) && lo_ok && hi_ok)
            inr[ki] = 1'b1;
      end
   end

   // Lowest pending entry is served first, the rest in later cycles.
   always @*
   begin
      grant = 6'h00;
      for (gi = 5; gi >= 0; gi = gi - 1)
      begin
         if (pend_reg[gi])
            grant = 6'h01 << gi;
      end
   end

   wire [5:0] entry    = inr & ~range_in_progress;
   wire [5:0] new_pend = cmp_method ? entry : hit;
   reg  [2:0] gidx;
   reg  [15:0] gtask;

   always @*
   begin
      gidx = 3'h0;
      for (xi = 0; xi < 6; xi = xi + 1)
      begin
         if (grant[xi])
            gidx = xi[2:0];
      end
      gtask = act_task[gidx];
   end

   // ----------------------------------------------------------------------
   // Loader and command sequencing
   // ----------------------------------------------------------------------
   wire port_match_start = (mcc_port == {13'h0000, act_port_reg});
   wire restart = state_reg[2] && !err;

   always @(posedge clk)
   begin
      if (!rst_b)
      begin
         state_reg              <= ST_IDLE;
         ld_addr_reg            <= 5'h00;
         cap_idx_reg            <= 5'h00;
         cap_en_reg             <= 1'b0;
         cmd_port_reg           <= 16'h0000;
         cmd_code_reg           <= 16'h0000;
         cand_cnt_reg           <= 16'h0000;
         act_cnt_reg            <= 3'h0;
         act_port_reg           <= 3'h0;
         tbl_valid_reg          <= 1'b0;
         cmp_running            <= 1'b0;
         cmp_method             <= 1'b0;
         instruction_error_flag <= 1'b0;
         trc_done               <= 1'b0;
         for (i = 0; i < 6; i = i + 1)
         begin
            cand_lo[i]   <= 32'h00000000;
            cand_hi[i]   <= 32'h00000000;
            cand_task[i] <= 16'h0000;
            act_lo[i]    <= 32'h00000000;
            act_hi[i]    <= 32'h00000000;
            act_task[i]  <= 16'h0000;
         end
      end
      else
      begin
         trc_done    <= 1'b0;
         cap_idx_reg <= ld_addr_reg;
         cap_en_reg  <= state_reg[1];
         if (cap_en_reg)
         begin
            if (cmd_rng)
            begin
               for (i = 0; i < 6; i = i + 1)
               begin
                  if (cap_idx_reg == i * `CCT_RNG_STRIDE)
                     cand_lo[i][15:0] <= ram_data;
                  if (cap_idx_reg == i * `CCT_RNG_STRIDE + 1)
                     cand_lo[i][31:16] <= ram_data;
                  if (cap_idx_reg == i * `CCT_RNG_STRIDE + 2)
                     cand_hi[i][15:0] <= ram_data;
                  if (cap_idx_reg == i * `CCT_RNG_STRIDE + 3)
                     cand_hi[i][31:16] <= ram_data;
                  if (cap_idx_reg == i * `CCT_RNG_STRIDE + 4)
                     cand_task[i] <= ram_data;
               end
            end
            else
            begin
               if (cap_idx_reg == 5'h00)
                  cand_cnt_reg <= ram_data;
               for (i = 0; i < 6; i = i + 1)
               begin
                  if (cap_idx_reg == i * `CCT_TGT_STRIDE + 1)
                     cand_lo[i][15:0] <= ram_data;
                  if (cap_idx_reg == i * `CCT_TGT_STRIDE + 2)
                     cand_lo[i][31:16] <= ram_data;
                  if (cap_idx_reg == i * `CCT_TGT_STRIDE + 3)
                     cand_task[i] <= ram_data;
               end
            end
         end
         case (state_reg)
            ST_IDLE:
            begin
               ld_addr_reg <= 5'h00;
               if (trc_valid)
               begin
                  cmd_port_reg <= trc_port;
                  cmd_code_reg <= trc_code;
                  state_reg    <= ST_LOAD;
               end
            end
            ST_LOAD:
            begin
               if (ld_addr_reg != `CCT_TBL_LAST)
                  ld_addr_reg <= ld_addr_reg + 5'h01;
               if (cap_en_reg && (cap_idx_reg == `CCT_TBL_LAST))
                  state_reg <= ST_CHECK;
            end
            ST_CHECK:
            begin
               state_reg              <= ST_IDLE;
               trc_done               <= 1'b1;
               instruction_error_flag <= err;
               if (!err)
               begin
                  // A rejected table leaves the one in force untouched.
                  for (i = 0; i < 6; i = i + 1)
                  begin
                     act_lo[i]   <= cand_lo[i];
                     act_hi[i]   <= cand_hi[i];
                     act_task[i] <= cand_task[i];
                  end
                  act_cnt_reg   <= cand_cnt_reg[2:0];
                  act_port_reg  <= psel;
                  tbl_valid_reg <= 1'b1;
                  cmp_method    <= cmd_rng;
                  cmp_running   <= !cmd_code_reg[1];
               end
            end
            default:
            begin
               state_reg <= ST_IDLE;
            end
         endcase
         if (!state_reg[2] && mcc_start && tbl_valid_reg &&
             port_match_start)
            cmp_running <= 1'b1;
         if (!state_reg[2] && mcc_stop && port_match_start)
            cmp_running <= 1'b0;
         if (program_mode)
         begin
            tbl_valid_reg <= 1'b0;
            cmp_running   <= 1'b0;
         end
      end
   end

   // ----------------------------------------------------------------------
   // Event issue
   // ----------------------------------------------------------------------
   always @(posedge clk)
   begin
      if (!rst_b)
      begin
         pv_prev_reg       <= 32'h00000000;
         pend_reg          <= 6'h00;
         range_in_progress <= 6'h00;
         evt_valid         <= 1'b0;
         evt_task          <= 16'h0000;
      end
      else
      begin
         pv_prev_reg <= pv;
         evt_valid   <= 1'b0;
         if (restart || program_mode)
         begin
            // Clearing the flags lets a value already inside a range fire
            // once more after the table is stored again.
            pend_reg          <= 6'h00;
            range_in_progress <= 6'h00;
         end
         else
         begin
            pend_reg          <= (pend_reg & ~grant) | new_pend;
            range_in_progress <= inr;
            if (grant != 6'h00)
            begin
               if (!(cmp_method && (gtask == `CCT_TASK_QUIET)))
               begin
                  evt_valid <= 1'b1;
                  evt_task  <= cmp_method ? gtask :
                               (gtask & `CCT_TASK_MASK);
               end
            end
         end
      end
   end

endmodule

/* File: verilog/cct_consts.vh */
/*
   Constants of the counter compare table unit: command codes, table
   layout, special task words and limits.
   Assumes it is included by bare name from the design files.
*/
`ifndef CCT_CONSTS_VH
`define CCT_CONSTS_VH

// ----------------------------------------------------------------------
// Port and control codes
// ----------------------------------------------------------------------
`define CCT_PORT_MAX      16'h0005
`define CCT_CODE_MAX      16'h0003
`define CCT_CODE_TGT_RUN  16'h0000
`define CCT_CODE_RNG_RUN  16'h0001
`define CCT_CODE_TGT_ONLY 16'h0002
`define CCT_CODE_RNG_ONLY 16'h0003

// ----------------------------------------------------------------------
// Table layout
// ----------------------------------------------------------------------
`define CCT_TBL_WORDS     5'h1E
`define CCT_TBL_LAST      5'h1D
`define CCT_MAX_TARGETS   16'h0006
`define CCT_TGT_STRIDE    3
`define CCT_RNG_STRIDE    5
`define CCT_DIR_BIT       15
`define CCT_TASK_MASK     16'h7FFF
`define CCT_TASK_OFF      16'hFFFF
`define CCT_TASK_QUIET    16'hAAAA

`endif

/* File: verilog/cct_table_ram.v */
/*
   Staging memory for one comparison table, written by the host word by
   word and read back by the table loader.
   Assumes a single clock; read data appear one cycle after the address.
*/
`timescale 1ns/100ps
module cct_table_ram
#(
   parameter AW    = 5,
   parameter DW    = 16,
   parameter DEPTH = 32
)
(
   // Clock and reset
   input  wire          clk,
   input  wire          rst_b,
   // Write side
   input  wire          wr_en,
   input  wire [AW-1:0] wr_addr,
   input  wire [DW-1:0] wr_data,
   // Read side
   input  wire [AW-1:0] rd_addr,
   output reg  [DW-1:0] rd_data
);

   reg [DW-1:0] mem [0:DEPTH-1];

   // ----------------------------------------------------------------------
   // Storage
   // ----------------------------------------------------------------------
   always @(posedge clk)
   begin
      if (wr_en)
      begin
         mem[wr_addr] <= wr_data;
      end
   end

   always @(posedge clk)
   begin
      if (!rst_b)
      begin
         rd_data <= {DW{1'b0}};
      end
      else
      begin
         rd_data <= mem[rd_addr];
      end
   end

endmodule
